// file: hdl/mmd_pkg.sv
// Package for the memory map bank decoder: address bounds, variants, bank pointer layout.
// Assumes a 16-bit CPU address and an 8-bit direct operand.
package mmd_pkg;
    localparam int          ADDR_W          = 16;
    localparam int          BANK_W          = 3;
    localparam logic [15:0] IO_LO           = 16'h0000;
    localparam logic [15:0] IO_HI           = 16'h007f;
    localparam logic [15:0] XIO_LO          = 16'h0f80;
    localparam logic [15:0] XIO_HI          = 16'h0fff;
    localparam logic [15:0] RAM_LO          = 16'h0090;
    localparam logic [15:0] DIR_FIX_HI      = 16'h00ff;
    localparam logic [15:0] GPR_LO          = 16'h0100;
    localparam logic [15:0] GPR_HI          = 16'h01ff;
    localparam logic [15:0] RAM_HI_LARGE    = 16'h047f;
    localparam logic [15:0] RAM_HI_MID      = 16'h028f;
    localparam logic [15:0] RAM_HI_SMALL    = 16'h018f;
    localparam logic [15:0] NVR_LO          = 16'hffbb;
    localparam logic [15:0] NVR_HI          = 16'hffbf;
    localparam logic [15:0] VEC_LO          = 16'hffc0;
    localparam logic [15:0] VEC_HI          = 16'hffff;
    localparam logic [15:0] BANK_STEP       = 16'h0080;
    localparam logic [15:0] BANK_BASE       = 16'h0080;
    localparam logic [7:0]  DIR_IO_HI       = 8'h7f;
    localparam logic [7:0]  DIR_RAM_LO      = 8'h90;
    localparam logic [2:0]  BANK_PTR_RESET  = 3'h0;
    // Flash lower bounds per size; the sized area ends at the top of space, the second window at 0x1FFF
    localparam logic [15:0] FLASH_LO_4K     = 16'hf000;
    localparam logic [15:0] FLASH_LO_8K     = 16'he000;
    localparam logic [15:0] FLASH_LO_16K    = 16'hc000;
    localparam logic [15:0] FLASH_LO_32K    = 16'h8000;
    localparam logic [15:0] FLASH2_LO       = 16'h1000;
    localparam logic [15:0] FLASH2_HI       = 16'h1fff;

    typedef enum logic [1:0] {
        MMD_RAM_SMALL,
        MMD_RAM_MID,
        MMD_RAM_LARGE
    } mmd_ram_size_t;

    typedef enum logic [2:0] {
        MMD_AREA_NONE,
        MMD_AREA_IO,
        MMD_AREA_XIO,
        MMD_AREA_RAM,
        MMD_AREA_FLASH
    } mmd_area_t;
endpackage

// file: hdl/mmd_xlat_if.sv
// Carries a direct-addressing translation request and its result between modules.
// Assumes both ends share one clock; the path is combinational.
`timescale 1ns/10ps
`default_nettype none
interface mmd_xlat_if;
    logic [7:0]  operand;
    logic [2:0]  bank_pointer;
    logic [15:0] address;
    modport requester (output operand, output bank_pointer, input address);
    modport translator (input operand, input bank_pointer, output address);
endinterface
`default_nettype wire

// file: hdl/mmd_bank_xlat.sv
// Direct operand to full address translation through the bank pointer.
// Assumes the caller qualifies the result against the RAM bound.
`timescale 1ns/10ps
`default_nettype none
module mmd_bank_xlat
    import mmd_pkg::*;
(
    mmd_xlat_if.translator x
);
    always_comb begin
        if (x.operand <= DIR_IO_HI) begin
            x.address = {8'h00, x.operand};
        end else if (x.bank_pointer == BANK_PTR_RESET) begin
            x.address = {8'h00, x.operand};
        end else begin
            x.address = BANK_BASE + BANK_STEP * {13'h0000, x.bank_pointer}
                        + {9'h000, x.operand[6:0]};
        end
    end
endmodule
`default_nettype wire

// file: hdl/mmd_decoder.sv
// Memory map decoder: classifies CPU and direct-addressing accesses into target selects.
// Assumes one CPU request per cycle on i_core_clk; selects come out one cycle later.
// How it works
// - 64 KB space split into I/O, extended I/O, RAM and Flash areas
// - 0x0000-0x007F selects I/O registers, by memory or direct access
// - 0x0F80-0x0FFF selects extended I/O registers by memory access
// - Direct operands 0x90-0xFF reach RAM with no translation while the bank pointer is zero
// - Banked RAM top is 0x047F, 0x028F or 0x018F by RAM variant
// - RAM 0x0100-0x01FF also flagged as general-purpose register area
// - Register area stays ordinary RAM for plain reads and writes
// - Program area served by Flash sized per variant
// - 0xFFC0-0xFFFF flagged as vector table
// - Vector table sits at top of Flash, ending at 0xFFFF
// - 0xFFBB-0xFFBF flagged as non-volatile register data
// - Direct operands 0x00-0x7F ignore the bank pointer
// - Bank pointer resets to zero, giving identity for 0x90-0xFF
// - Pointer 1..7 maps operand 0x80-0xFF to 128-byte banks from 0x0100
// - Banked accesses beyond physical RAM are refused
`timescale 1ns/10ps
`default_nettype none
module mmd_decoder
    import mmd_pkg::*;
#(
    parameter mmd_ram_size_t RAM_SIZE   = MMD_RAM_LARGE,
    parameter logic [15:0]   FLASH_LO   = FLASH_LO_32K
)
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_req,
    input  wire logic        i_we,
    input  wire logic        i_direct,
    input  wire logic        i_gpr,
    input  wire logic [15:0] i_addr,
    input  wire logic        i_bp_we,
    input  wire logic [2:0]  i_bp_wdata,
    output logic             o_io_sel,
    output logic             o_xio_sel,
    output logic             o_ram_sel,
    output logic             o_flash_sel,
    output logic             o_gpr_area,
    output logic             o_nvr_area,
    output logic             o_vec_area,
    output logic             o_we,
    output logic             o_refused,
    output logic [15:0]      o_addr,
    output logic [2:0]       o_bank_pointer
);
    mmd_xlat_if xl ();

    logic [2:0]  bank_pointer_ff;
    logic [15:0] eff_addr;
    logic [15:0] ram_hi;
    logic        hit_io;
    logic        hit_xio;
    logic        hit_ram;
    logic        hit_flash;
    logic        hit_any;

    logic        io_sel_ff;
    logic        xio_sel_ff;
    logic        ram_sel_ff;
    logic        flash_sel_ff;
    logic        gpr_ff;
    logic        nvr_ff;
    logic        vec_ff;
    logic        we_ff;
    logic        refused_ff;
    logic [15:0] addr_ff;

    assign xl.operand      = i_addr[7:0];
    assign xl.bank_pointer = bank_pointer_ff;

    mmd_bank_xlat u_xlat (
        .x (xl.translator)
    );

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bank_pointer_ff <= BANK_PTR_RESET;
        end else if (i_bp_we) begin
            bank_pointer_ff <= i_bp_wdata;
        end
    end

    always_comb begin
        unique case (RAM_SIZE)
            MMD_RAM_SMALL: ram_hi = RAM_HI_SMALL;
            MMD_RAM_MID:   ram_hi = RAM_HI_MID;
            MMD_RAM_LARGE: ram_hi = RAM_HI_LARGE;
            default:       ram_hi = RAM_HI_SMALL;
        endcase
    end

    always_comb begin
        // General register addressing gives a byte offset into the register area
        if (i_gpr) begin
            eff_addr = GPR_LO + {8'h00, i_addr[7:0]};
        end else if (i_direct) begin
            eff_addr = xl.address;
        end else begin
            eff_addr = i_addr;
        end
    end

    assign hit_io    = (eff_addr <= IO_HI);
    assign hit_xio   = !i_direct && !i_gpr && (eff_addr >= XIO_LO) && (eff_addr <= XIO_HI);
    assign hit_ram   = (eff_addr >= RAM_LO) && (eff_addr <= ram_hi);
    assign hit_flash = !i_direct && !i_gpr
                       && (((eff_addr >= FLASH_LO) && (eff_addr <= VEC_HI))
                       || ((eff_addr >= FLASH2_LO) && (eff_addr <= FLASH2_HI)));
    assign hit_any   = hit_io || hit_xio || hit_ram || hit_flash;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            io_sel_ff <= 1'b0;
        end else begin
            io_sel_ff <= i_req && hit_io;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            xio_sel_ff <= 1'b0;
        end else begin
            xio_sel_ff <= i_req && hit_xio;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ram_sel_ff <= 1'b0;
        end else begin
            ram_sel_ff <= i_req && hit_ram;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            flash_sel_ff <= 1'b0;
        end else begin
            flash_sel_ff <= i_req && hit_flash;
        end
    end

    // Flash is read-only from the CPU side, so its write strobe is dropped
    // No strobe when refused
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            we_ff <= 1'b0;
        end else begin
            we_ff <= i_req && i_we && hit_any && !hit_flash;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            refused_ff <= 1'b0;
        end else begin
            refused_ff <= i_req && !hit_any;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            gpr_ff <= 1'b0;
        end else begin
            gpr_ff <= i_req && hit_ram && (eff_addr >= GPR_LO) && (eff_addr <= GPR_HI);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            nvr_ff <= 1'b0;
        end else begin
            nvr_ff <= i_req && hit_flash && (eff_addr >= NVR_LO) && (eff_addr <= NVR_HI);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            vec_ff <= 1'b0;
        end else begin
            vec_ff <= i_req && hit_flash && (eff_addr >= VEC_LO);
        end
    end

    // Holds the last taken address, so idle cycles leave it alone
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            addr_ff <= 16'h0000;
        end else if (i_req) begin
            addr_ff <= eff_addr;
        end
    end

    assign o_io_sel       = io_sel_ff;
    assign o_xio_sel      = xio_sel_ff;
    assign o_ram_sel      = ram_sel_ff;
    assign o_flash_sel    = flash_sel_ff;
    assign o_gpr_area     = gpr_ff;
    assign o_nvr_area     = nvr_ff;
    assign o_vec_area     = vec_ff;
    assign o_we           = we_ff;
    assign o_refused      = refused_ff;
    assign o_addr         = addr_ff;
    assign o_bank_pointer = bank_pointer_ff;
endmodule
`default_nettype wire

// file: verif/mmd_decoder_monitor.sv
// Checker for the memory map decoder: selects against the requests that caused them.
// Assumes the large RAM variant and the default Flash floor.
`timescale 1ns/10ps
`default_nettype none
module mmd_decoder_monitor (
    input wire logic        i_core_clk,
    input wire logic        i_rstn,
    input wire logic        i_req,
    input wire logic        i_we,
    input wire logic        i_direct,
    input wire logic        i_gpr,
    input wire logic [15:0] i_addr,
    input wire logic        i_bp_we,
    input wire logic [2:0]  i_bp_wdata,
    input wire logic        o_io_sel,
    input wire logic        o_xio_sel,
    input wire logic        o_ram_sel,
    input wire logic        o_flash_sel,
    input wire logic        o_gpr_area,
    input wire logic        o_nvr_area,
    input wire logic        o_vec_area,
    input wire logic        o_we,
    input wire logic        o_refused,
    input wire logic [15:0] o_addr,
    input wire logic [2:0]  o_bank_pointer
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    wire logic mem = i_req && !i_direct && !i_gpr;
    io_select_a: assert property (mem && i_addr <= 16'h007f
        |=> o_io_sel && o_addr == $past(i_addr)) else $error("io select missing");
    xio_select_a: assert property (mem && i_addr[15:7] == 9'h01f |=> o_xio_sel)
        else $error("extended io select missing");
    vec_area_a: assert property (mem && i_addr >= 16'hffc0 |=> o_flash_sel && o_vec_area)
        else $error("vector area missing");
    nvr_area_a: assert property (mem && i_addr inside {[16'hffbb:16'hffbf]}
        |=> o_nvr_area && !o_vec_area) else $error("nvr area wrong");
    write_gate_a: assert property (o_we |-> $past(i_we) && !o_flash_sel && !o_refused)
        else $error("bad write strobe");
    bank_load_a: assert property (i_bp_we |=> o_bank_pointer == $past(i_bp_wdata))
        else $error("bank pointer not loaded");
    direct_low_a: assert property (i_req && i_direct && !i_gpr && !i_addr[7]
        |=> o_io_sel && o_addr == {8'h00, $past(i_addr[7:0])}) else $error("direct low moved");
    gpr_map_a: assert property (i_req && i_gpr |=> o_gpr_area
        && o_addr == {8'h01, $past(i_addr[7:0])}) else $error("register area wrong");
    idle_quiet_a: assert property (!i_req |=> !(o_io_sel || o_ram_sel || o_refused))
        else $error("select without request");
    cover property (i_req && i_direct && o_bank_pointer == 3'h7);
    cover property (o_refused);
    cover property (o_gpr_area && o_we);
endmodule
bind mmd_decoder mmd_decoder_monitor mmd_decoder_monitor_inst (
    .i_core_clk     (i_core_clk),
    .i_rstn         (i_rstn),
    .i_req          (i_req),
    .i_we           (i_we),
    .i_direct       (i_direct),
    .i_gpr          (i_gpr),
    .i_addr         (i_addr),
    .i_bp_we        (i_bp_we),
    .i_bp_wdata     (i_bp_wdata),
    .o_io_sel       (o_io_sel),
    .o_xio_sel      (o_xio_sel),
    .o_ram_sel      (o_ram_sel),
    .o_flash_sel    (o_flash_sel),
    .o_gpr_area     (o_gpr_area),
    .o_nvr_area     (o_nvr_area),
    .o_vec_area     (o_vec_area),
    .o_we           (o_we),
    .o_refused      (o_refused),
    .o_addr         (o_addr),
    .o_bank_pointer (o_bank_pointer)
);
`default_nettype wire

// file: verif/mmd_cpu_model.sv
// CPU side model: one access or one bank pointer load per call.
// Assumes the decoder takes requests on the rising edge of i_core_clk.
`timescale 1ns/10ps
`default_nettype none
module mmd_cpu_model (
    input  wire logic        i_core_clk,
    output logic             o_req,
    output logic             o_we,
    output logic             o_direct,
    output logic             o_gpr,
    output logic             o_bp_we,
    output logic [15:0]      o_addr,
    output logic [2:0]       o_bp_wdata
);
    initial {o_req, o_we, o_direct, o_gpr, o_bp_we, o_addr, o_bp_wdata} = '0;
    task automatic access(input logic [2:0] wdg, input logic [15:0] a, input logic bw,
                          input logic [2:0] bv);
        @(posedge i_core_clk);
        #1;
        {o_we, o_direct, o_gpr} = wdg;
        o_req = !bw;
        o_bp_we = bw;
        o_addr = a;
        o_bp_wdata = bv;
        @(posedge i_core_clk);
        #1;
        o_req = 1'b0;
        o_bp_we = 1'b0;
        // Released address and pointer data show the inverse; write, direct and gpr keep their value
        o_addr = ~a;
        o_bp_wdata = ~bv;
    endtask
endmodule
`default_nettype wire

// file: verif/mmd_decoder_tb.sv
// Testbench for the memory map decoder: reset check, table of accesses, mid-part bounds, then a mid-run reset.
// Assumes the large RAM variant and the default Flash floor.
`timescale 1ns/10ps
`default_nettype none
module mmd_decoder_tb;
    typedef struct packed {
        logic [2:0]  bp;
        logic [2:0]  wdg;
        logic [15:0] a;
        logic [8:0]  e;
        logic [15:0] ea;
    } mmd_row_t;
    logic i_core_clk, i_rstn;
    logic req, we, dir, gpr, bp_we;
    logic [15:0] addr;
    logic [2:0] bp_wdata;
    wire logic [15:0] o_addr;
    wire logic [2:0] o_bank_pointer;
    wire logic [8:0] flags;
    wire logic [8:0] flags_mid;
    wire logic [15:0] o_addr_mid;
    int fails, check_count, cyc;
    mmd_row_t rows [15];
    mmd_cpu_model mmd_cpu_model_inst (.i_core_clk(i_core_clk), .o_req(req), .o_we(we),
        .o_direct(dir), .o_gpr(gpr), .o_bp_we(bp_we), .o_addr(addr), .o_bp_wdata(bp_wdata));
    mmd_decoder mmd_decoder_inst (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_req(req),
        .i_we(we), .i_direct(dir), .i_gpr(gpr), .i_addr(addr), .i_bp_we(bp_we),
        .i_bp_wdata(bp_wdata), .o_io_sel(flags[8]), .o_xio_sel(flags[7]), .o_ram_sel(flags[6]),
        .o_flash_sel(flags[5]), .o_gpr_area(flags[4]), .o_nvr_area(flags[3]),
        .o_vec_area(flags[2]), .o_we(flags[1]), .o_refused(flags[0]), .o_addr(o_addr),
        .o_bank_pointer(o_bank_pointer));
    // Mid RAM part beside the large one, fed the same requests
    mmd_decoder #(.RAM_SIZE(mmd_pkg::MMD_RAM_MID)) mmd_decoder_mid_inst (
        .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_req(req), .i_we(we), .i_direct(dir),
        .i_gpr(gpr), .i_addr(addr), .i_bp_we(bp_we), .i_bp_wdata(bp_wdata),
        .o_io_sel(flags_mid[8]), .o_xio_sel(flags_mid[7]), .o_ram_sel(flags_mid[6]),
        .o_flash_sel(flags_mid[5]), .o_gpr_area(flags_mid[4]), .o_nvr_area(flags_mid[3]),
        .o_vec_area(flags_mid[2]), .o_we(flags_mid[1]), .o_refused(flags_mid[0]),
        .o_addr(o_addr_mid), .o_bank_pointer());
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            print_verdict();
        end
    end
    initial begin
        // Row: pointer, {write,direct,gpr}, address, flags, effective address
        rows = '{'{3'h0, 3'h0, 16'h007f, 9'h100, 16'h007f},
                 '{3'h0, 3'h4, 16'h0f80, 9'h082, 16'h0f80},
                 '{3'h0, 3'h0, 16'h0080, 9'h001, 16'h0080},
                 '{3'h0, 3'h4, 16'h0150, 9'h052, 16'h0150},
                 '{3'h0, 3'h0, 16'hffbb, 9'h028, 16'hffbb},
                 '{3'h0, 3'h4, 16'hffc0, 9'h024, 16'hffc0},
                 '{3'h0, 3'h0, 16'h1000, 9'h020, 16'h1000},
                 '{3'h0, 3'h0, 16'h0480, 9'h001, 16'h0480},
                 '{3'h3, 3'h2, 16'h0010, 9'h100, 16'h0010},
                 '{3'h0, 3'h2, 16'h00a0, 9'h040, 16'h00a0},
                 '{3'h7, 3'h2, 16'h00ff, 9'h040, 16'h047f},
                 '{3'h1, 3'h2, 16'h0080, 9'h050, 16'h0100},
                 '{3'h0, 3'h1, 16'h0020, 9'h050, 16'h0120},
                 '{3'h7, 3'h3, 16'h0020, 9'h050, 16'h0120},
                 '{3'h0, 3'h0, 16'h7fff, 9'h001, 16'h7fff}};
        i_rstn = 1'b0;
        repeat (2) @(posedge i_core_clk);
        #1;
        check(16'(o_bank_pointer), 16'h0000);
        check(16'(flags), 16'h0000);
        i_rstn = 1'b1;
        foreach (rows[i]) begin
            mmd_cpu_model_inst.access(3'h0, 16'h0000, 1'b1, rows[i].bp);
            mmd_cpu_model_inst.access(rows[i].wdg, rows[i].a, 1'b0, 3'h0);
            check(16'(flags), 16'(rows[i].e));
            check(o_addr, rows[i].ea);
        end
        // Mid part: its last usable bank byte is 0x028f, the large part goes on
        mmd_cpu_model_inst.access(3'h0, 16'h0000, 1'b1, 3'h4);
        mmd_cpu_model_inst.access(3'h2, 16'h008f, 1'b0, 3'h0);
        check(16'(flags_mid), 16'h0040);
        check(o_addr_mid, 16'h028f);
        mmd_cpu_model_inst.access(3'h2, 16'h0090, 1'b0, 3'h0);
        check(16'(flags_mid), 16'h0001);
        check(16'(flags), 16'h0040);
        mmd_cpu_model_inst.access(3'h4, 16'h0290, 1'b0, 3'h0);
        check(16'(flags_mid), 16'h0001);
        check(16'(flags), 16'h0042);
        // Reset in mid-run must drop a loaded pointer at once
        mmd_cpu_model_inst.access(3'h0, 16'h0000, 1'b1, 3'h5);
        check(16'(o_bank_pointer), 16'h0005);
        i_rstn = 1'b0;
        #3;
        check(16'(o_bank_pointer), 16'h0000);
        @(posedge i_core_clk);
        #1;
        i_rstn = 1'b1;
        print_verdict();
    end
endmodule
`default_nettype wire
